//--- crpc_top.sv
// Clock, reset and power-mode controller with Avalon-MM registers
//
// Behaviour
// - Run mode clocks CPU and peripherals from the divided system clock.
// - In HALT the interrupt logic keeps its own clock enable.
// - Option strap picks oscillator divide-by-1 or divide-by-2.
// - Recovery register bit 0 adds a divide-by-16 prescaler.
// - Power-on reset and stop recovery both clear the prescaler.
// - Recovery bit 5 set inserts power-on delay after STOP wake.
// - Brownout holds internal reset and stops oscillator and clocks.
// - Deep brownout keeps reset and switches off brownout comparator.
// - Supply back above brownout point runs a full power-on reset.
// - STOP halts internal clock and oscillator until reset or wake.
// - STOP ends by wake pin or a reset source; restart at fixed vector.
// - Stop recovery keeps some bits and sets recovery bit 7.
// - HALT gates only the CPU clock; other clocks keep running, the watchdog only if WDM bit 2 is set.
// - An enabled interrupt ends HALT; execution then continues.
// - Enabled watchdog without refresh in time forces power-on reset.
// - Clear edges start power-on timer and 18-clock reset timer.
// - Power-on reset starts clocks and loads register defaults.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
`include "crpc_params.svh"
module crpc_top #(
  parameter int POR_CYC = `CRPC_T_POR_US * `CRPC_CLK_MHZ,
  parameter int WD_CYC = `CRPC_T_WD_US * `CRPC_CLK_MHZ
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [13:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic OSCILLATOR_INPUT_PIN,
  input wire logic BROWNOUT_COMPARATOR_LOW,
  input wire logic DEEP_BROWNOUT_COMPARATOR_LOW,
  input wire logic WAKE_PIN,
  input wire logic OPTION_DIV2,
  input wire logic STOP_REQ,
  input wire logic HALT_REQ,
  input wire logic IRQ_PENDING,
  input wire logic WATCHDOG_REFRESH,
  output logic SYSTEM_CLK_EN,
  output logic CPU_CLK_EN,
  output logic INTERRUPT_SIDE_CLOCK_EN,
  output logic OSC_ENABLE,
  output logic BROWNOUT_COMP_EN,
  output logic INTERNAL_RESET_B,
  output logic RESTART_PULSE,
  output logic [11:0] RESTART_VECTOR,
  output logic HALT_ACTIVE,
  output logic STOP_ACTIVE
);
  import crpc_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  crpc_pins_t pin_s1;
  crpc_pins_t pin_s2;
  crpc_pins_t pin_s3;
  always_ff @(posedge SYS_CLK) begin
    pin_s1 <= {OSCILLATOR_INPUT_PIN, BROWNOUT_COMPARATOR_LOW,
               DEEP_BROWNOUT_COMPARATOR_LOW, WAKE_PIN, OPTION_DIV2};
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end
  wire osc_edge = pin_s2.osc & ~pin_s3.osc;
  wire wake_rise = pin_s2.wake & ~pin_s3.wake;
  // Deep brownout disables the comparator, so it must hold reset by itself
  wire brown_now = pin_s2.brown | pin_s2.deep;

  // ****************************************
  // Register decode
  // ****************************************
  function automatic logic hit(input logic [11:0] idx,
                               input logic [11:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  wire [11:0] idx = AVS_ADDRESS[13:2];
  wire hit_vdc = hit(idx, `CRPC_IDX_VDC);
  wire hit_stop_recovery_ctrl4 = hit(idx, `CRPC_IDX_STOP_RECOVERY_CTRL4);
  wire hit_smr = hit(idx, `CRPC_IDX_SMR);
  wire hit_stop_recovery_ctrl1 = hit(idx, `CRPC_IDX_STOP_RECOVERY_CTRL1);
  wire hit_stop_recovery_ctrl2 = hit(idx, `CRPC_IDX_STOP_RECOVERY_CTRL2);
  wire hit_stop_recovery_ctrl3 = hit(idx, `CRPC_IDX_STOP_RECOVERY_CTRL3);
  wire hit_wdm = hit(idx, `CRPC_IDX_WDM);
  wire wr_fire = AVS_WRITE & ~AVS_WAITREQUEST;
  wire [7:0] wbyte = AVS_WRITEDATA[7:0];

  // ****************************************
  // State and timers
  // ****************************************
  crpc_state_t state;
  crpc_state_t next_state;
  logic [7:0] vdc;
  logic [7:0] stop_recovery_ctrl;
  logic [7:0] stop_recovery_ctrl1;
  logic [7:0] stop_recovery_ctrl2;
  logic [7:0] stop_recovery_ctrl3;
  logic [7:0] stop_recovery_ctrl4;
  logic [7:0] wdm;
  logic opt_div2;
  logic wd_en;
  logic [17:0] wd_cnt;
  logic watchdog_timer_clear;
  logic watchdog_timer_clear_q;
  logic short_reset_timer_clear;
  logic short_reset_timer_clear_q;
  logic armed;
  logic from_stop;
  logic por_busy;
  logic short_busy;
  logic sys_tick;

  wire in_run = (state == ST_RUN);
  wire in_halt = (state == ST_HALT);
  wire in_stop = (state == ST_STOP);
  wire wd_act = in_run | (in_halt & wdm[`CRPC_WDM_HALT]) |
                (in_stop & wdm[`CRPC_WDM_STOP]);
  wire wd_fire = wd_en & wd_act & (wd_cnt == 18'(WD_CYC - 1));
  wire stop_wake = in_stop & wake_rise & ~wd_fire & ~brown_now;
  wire delay_sel = stop_recovery_ctrl[`CRPC_SMR_DELAY];
  wire por_start = watchdog_timer_clear & ~watchdog_timer_clear_q;
  wire short_start = short_reset_timer_clear & ~short_reset_timer_clear_q;
  wire reset_done = armed & ~por_busy & ~short_busy;
  wire regs_clear = brown_now | (state == ST_BROWN) | wd_fire;
  wire osc_on = (next_state != ST_BROWN) & (next_state != ST_STOP);

  // Clear inputs drop low while a reset source is present
  wire next_watchdog_timer_clear = ~(brown_now | (state == ST_BROWN) | wd_fire |
                     (stop_wake & delay_sel));

  always_comb begin
    next_state = state;
    if (brown_now)
      next_state = ST_BROWN;
    else
      case (state)
        ST_BROWN: next_state = ST_POR;
        ST_POR: begin
          if (reset_done)
            next_state = ST_RUN;
        end
        ST_RUN: begin
          if (wd_fire)
            next_state = ST_POR;
          else if (STOP_REQ)
            next_state = ST_STOP;
          else if (HALT_REQ)
            next_state = ST_HALT;
        end
        ST_HALT: begin
          if (wd_fire)
            next_state = ST_POR;
          else if (IRQ_PENDING)
            next_state = ST_RUN;
        end
        ST_STOP: begin
          if (wd_fire)
            next_state = ST_POR;
          else if (stop_wake)
            next_state = delay_sel ? ST_POR : ST_RUN;
        end
        default: next_state = ST_POR;
      endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state <= ST_POR;
      watchdog_timer_clear <= 1'b0;
      watchdog_timer_clear_q <= 1'b0;
      short_reset_timer_clear <= 1'b0;
      short_reset_timer_clear_q <= 1'b0;
    end else begin
      state <= next_state;
      watchdog_timer_clear <= next_watchdog_timer_clear;
      watchdog_timer_clear_q <= watchdog_timer_clear;
      short_reset_timer_clear <= watchdog_timer_clear;
      short_reset_timer_clear_q <= short_reset_timer_clear;
    end
  end

  // Timers restarted since the last clear; old idle timers cannot end reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B || !next_watchdog_timer_clear)
      armed <= 1'b0;
    else if (short_start)
      armed <= 1'b1;
  end

  crpc_oneshot u_por_timer (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .start(por_start),
    .tick(1'b1),
    .load(18'(POR_CYC)),
    .busy(por_busy)
  );

  crpc_oneshot u_short_timer (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .start(short_start),
    .tick(osc_edge),
    .load(`CRPC_SHORT_CLKS),
    .busy(short_busy)
  );

  crpc_clkdiv u_clkdiv (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .osc_edge(osc_edge),
    .run(osc_on),
    .div2(opt_div2),
    .div16(stop_recovery_ctrl[`CRPC_SMR_PRESC]),
    .tick(sys_tick)
  );

  // ****************************************
  // Watchdog and strap capture
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B || regs_clear) begin
      wd_en <= 1'b0;
      wd_cnt <= 18'h0;
    end else if (WATCHDOG_REFRESH) begin
      wd_en <= 1'b1;
      wd_cnt <= 18'h0;
    end else if (wd_en && wd_act) begin
      wd_cnt <= wd_cnt + 18'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B)
      opt_div2 <= 1'b0;
    else if (state == ST_POR)
      opt_div2 <= pin_s2.div2;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B || regs_clear) begin
      vdc <= `CRPC_RST_VDC;
      stop_recovery_ctrl <= `CRPC_RST_SMR;
      stop_recovery_ctrl1 <= `CRPC_RST_SMRX;
      stop_recovery_ctrl2 <= `CRPC_RST_SMRX;
      stop_recovery_ctrl3 <= `CRPC_RST_SMRX;
      stop_recovery_ctrl4 <= `CRPC_RST_SMRX;
      wdm <= `CRPC_RST_WDM;
    end else begin
      if (wr_fire && hit_vdc)
        vdc[`CRPC_VDC_EN] <= wbyte[`CRPC_VDC_EN];
      if (wr_fire && hit_smr)
        stop_recovery_ctrl <= wbyte;
      if (wr_fire && hit_stop_recovery_ctrl1)
        stop_recovery_ctrl1 <= wbyte;
      if (wr_fire && hit_stop_recovery_ctrl2)
        stop_recovery_ctrl2 <= wbyte;
      if (wr_fire && hit_stop_recovery_ctrl3)
        stop_recovery_ctrl3 <= wbyte;
      if (wr_fire && hit_stop_recovery_ctrl4)
        stop_recovery_ctrl4 <= wbyte;
      if (wr_fire && hit_wdm)
        wdm <= wbyte;
      // Recovery wins over a write in the same cycle
      if (stop_wake) begin
        stop_recovery_ctrl[`CRPC_SMR_PRESC] <= 1'b0;
        stop_recovery_ctrl[`CRPC_SMR_FLAG] <= 1'b1;
      end
    end
  end

  wire [7:0] vdc_rd = {`CRPC_VDC_RO, 2'b00, vdc[`CRPC_VDC_EN]};
  wire [7:0] rd_byte = hit_vdc ? vdc_rd :
                       hit_smr ? stop_recovery_ctrl :
                       hit_stop_recovery_ctrl1 ? stop_recovery_ctrl1 :
                       hit_stop_recovery_ctrl2 ? stop_recovery_ctrl2 :
                       hit_stop_recovery_ctrl3 ? stop_recovery_ctrl3 :
                       hit_stop_recovery_ctrl4 ? stop_recovery_ctrl4 : 8'h00;

  // ****************************************
  // Avalon slave: one wait cycle per access
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST)
        AVS_READDATA <= {24'h0, rd_byte};
    end
  end

  // ****************************************
  // Clock enables and status outputs
  // ****************************************
  wire nx_run = (next_state == ST_RUN);
  wire nx_halt = (next_state == ST_HALT);
  wire nx_live = nx_run | nx_halt;
  wire nx_rst = (next_state == ST_POR) | (next_state == ST_BROWN);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B)
      from_stop <= 1'b0;
    else if (stop_wake)
      from_stop <= 1'b1;
    else if (regs_clear || nx_run)
      from_stop <= 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      SYSTEM_CLK_EN <= 1'b0;
      CPU_CLK_EN <= 1'b0;
      INTERRUPT_SIDE_CLOCK_EN <= 1'b0;
      OSC_ENABLE <= 1'b0;
      BROWNOUT_COMP_EN <= 1'b1;
      INTERNAL_RESET_B <= 1'b0;
      RESTART_PULSE <= 1'b0;
      RESTART_VECTOR <= `CRPC_STOP_VECTOR;
      HALT_ACTIVE <= 1'b0;
      STOP_ACTIVE <= 1'b0;
    end else begin
      SYSTEM_CLK_EN <= sys_tick & nx_live;
      CPU_CLK_EN <= sys_tick & nx_run;
      INTERRUPT_SIDE_CLOCK_EN <= sys_tick & nx_live;
      OSC_ENABLE <= osc_on;
      BROWNOUT_COMP_EN <= ~pin_s2.deep;
      INTERNAL_RESET_B <= ~nx_rst;
      RESTART_PULSE <= (stop_wake | from_stop) & nx_run &
                       ~in_run;
      RESTART_VECTOR <= `CRPC_STOP_VECTOR;
      HALT_ACTIVE <= nx_halt;
      STOP_ACTIVE <= (next_state == ST_STOP);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  brown_reset_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) brown_now |=> !INTERNAL_RESET_B && !OSC_ENABLE
    && !SYSTEM_CLK_EN) else $error("brownout did not hold reset");
  deep_comp_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) pin_s2.deep |=> !BROWNOUT_COMP_EN
    && !INTERNAL_RESET_B) else $error("deep brownout comparator on");
  brown_por_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) state == ST_BROWN && !brown_now |=>
    state == ST_POR ##2 por_busy) else $error("no power-on after brownout");
  stop_clocks_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) in_stop && $past(in_stop) |->
    !OSC_ENABLE && !CPU_CLK_EN) else $error("clock running in stop");
  stop_fast_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) stop_wake && !delay_sel |=> in_run &&
    RESTART_PULSE && RESTART_VECTOR == `CRPC_STOP_VECTOR)
    else $error("fast stop wake failed");
  stop_delay_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) stop_wake && delay_sel |=>
    (state == ST_POR && !INTERNAL_RESET_B) [*8])
    else $error("stop wake skipped delay");
  stop_flag_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) stop_wake && !brown_now |=>
    stop_recovery_ctrl[`CRPC_SMR_FLAG] && !stop_recovery_ctrl[`CRPC_SMR_PRESC])
    else $error("recovery flag not set");
  halt_gate_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) in_halt && $past(in_halt) |->
    !CPU_CLK_EN && OSC_ENABLE && SYSTEM_CLK_EN == INTERRUPT_SIDE_CLOCK_EN)
    else $error("halt gated wrong clock");
  halt_exit_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) in_halt && IRQ_PENDING && !wd_fire
    && !brown_now |=> in_run) else $error("interrupt did not end halt");
  wd_reset_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) wd_fire && !brown_now |=> state == ST_POR
    && !INTERNAL_RESET_B ##1 !wd_en) else $error("watchdog reset missing");
  timer_run_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) por_start |=> por_busy [*8])
    else $error("power-on timer did not start");
  presc_off_a: assert property (@(posedge SYS_CLK)
    disable iff (!RST_B) wd_fire |=> !stop_recovery_ctrl[`CRPC_SMR_PRESC]
    && stop_recovery_ctrl[`CRPC_SMR_DELAY]) else $error("prescaler not reset");
  stop_wake_c: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    stop_wake);
  halt_exit_c: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    in_halt ##1 in_run);
  wd_fire_c: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    wd_fire);
  brown_c: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    state == ST_BROWN ##1 state == ST_POR);
endmodule

//--- crpc_params.svh
// Offsets, field positions, reset values and timing figures
`ifndef CRPC_PARAMS_SVH
`define CRPC_PARAMS_SVH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define CRPC_IDX_VDC 12'hd0c
`define CRPC_IDX_STOP_RECOVERY_CTRL4 12'hf0a
`define CRPC_IDX_SMR 12'hf0b
`define CRPC_IDX_STOP_RECOVERY_CTRL1 12'hf0c
`define CRPC_IDX_STOP_RECOVERY_CTRL2 12'hf0d
`define CRPC_IDX_STOP_RECOVERY_CTRL3 12'hf0e
`define CRPC_IDX_WDM 12'hf0f
// ****************************************
// Reset values and fields
// ****************************************
`define CRPC_RST_VDC 8'hf8
`define CRPC_RST_SMR 8'h20
`define CRPC_RST_SMRX 8'h00
`define CRPC_RST_WDM 8'h0d
`define CRPC_VDC_RO 5'h1f
`define CRPC_VDC_EN 0
`define CRPC_SMR_PRESC 0
`define CRPC_SMR_DELAY 5
`define CRPC_SMR_FLAG 7
`define CRPC_WDM_HALT 2
`define CRPC_WDM_STOP 3
// ****************************************
// Timing
// ****************************************
`define CRPC_CLK_MHZ 50
`define CRPC_T_POR_US 5000
`define CRPC_T_WD_US 5000
`define CRPC_SHORT_CLKS 18'd18
`define CRPC_STOP_VECTOR 12'h00c
`endif

//--- crpc_pkg.sv
// Types shared by the clock, reset and power controller
package crpc_pkg;
  typedef enum logic [2:0] {
    ST_BROWN,
    ST_POR,
    ST_RUN,
    ST_HALT,
    ST_STOP
  } crpc_state_t;
  typedef struct packed {
    logic osc;
    logic brown;
    logic deep;
    logic wake;
    logic div2;
  } crpc_pins_t;
endpackage

//--- crpc_clkdiv.sv
// Oscillator divider: divide-by-1/2 stage and divide-by-16 prescaler
`timescale 1ns/100ps
module crpc_clkdiv (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic osc_edge,
  input wire logic run,
  input wire logic div2,
  input wire logic div16,
  output logic tick
);
  import crpc_pkg::*;
  logic half;
  logic [3:0] presc;
  wire stage = osc_edge & (~div2 | half);
  wire presc_top = (presc == 4'hf);
  assign tick = run & stage & (~div16 | presc_top);
  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      half <= 1'b0;
      presc <= 4'h0;
    end else begin
      if (osc_edge)
        half <= ~half;
      if (stage)
        presc <= presc + 4'h1;
    end
  end
endmodule

//--- crpc_oneshot.sv
// One-shot down counter started by a rising clear edge
`timescale 1ns/100ps
module crpc_oneshot (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic tick,
  input wire logic [17:0] load,
  output logic busy
);
  import crpc_pkg::*;
  logic [17:0] cnt;
  assign busy = (cnt != 18'h0);
  always_ff @(posedge clk) begin
    if (!rst_b)
      cnt <= 18'h0;
    else if (start)
      cnt <= load;
    else if (tick && busy)
      cnt <= cnt - 18'h1;
  end
endmodule

//--- crpc_osc_model.sv
// Oscillator source model feeding the oscillator input pin
`timescale 1ns/100ps
module crpc_osc_model #(
  parameter int HALF_NS = 40
) (
  input wire logic osc_enable,
  input wire logic hold,
  output logic osc_pin
);
  // ****
  // Oscillation
  // ****
  initial osc_pin = 1'b0;
  // Stands low while disabled or held, toggles every HALF_NS otherwise
  always begin
    #HALF_NS;
    osc_pin = (osc_enable && !hold) ? ~osc_pin : 1'b0;
  end
endmodule

//--- clock_reset_power_ctrl_tb.sv
// Self-checking bench for the clock, reset and power controller
`timescale 1ns/100ps
`include "crpc_params.svh"
module clock_reset_power_ctrl_tb;
  localparam int POR = 40;
  localparam int WD = 200;
  localparam int HALF = 40;
  localparam int WIN = 640;
  localparam int E1 = WIN * 20 / (2 * HALF);
  typedef struct {
    logic [11:0] idx;
    bit wr;
    logic [7:0] wd;
    logic [7:0] exp;
  } crpc_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic wait_r, osc, sys_en, cpu_en, int_en, osc_en, bo_en, irst_b, rpulse;
  logic [11:0] rvec;
  logic halt_a, stop_a;
  logic brown = 1'b0;
  logic deep = 1'b0;
  logic wake = 1'b0;
  logic div2 = 1'b0;
  logic stop_req = 1'b0;
  logic halt_req = 1'b0;
  logic irq = 1'b0;
  logic wd_ref = 1'b0;
  logic hold = 1'b0;
  int err_count = 0;
  int checked = 0;
  int n, lo, s, c, t;
  logic [7:0] d;
  crpc_row_t rows [14] = '{
    '{`CRPC_IDX_VDC, 0, 8'h00, 8'hf8}, '{`CRPC_IDX_STOP_RECOVERY_CTRL4, 0, 8'h00, 8'h00},
    '{`CRPC_IDX_SMR, 0, 8'h00, 8'h20}, '{`CRPC_IDX_STOP_RECOVERY_CTRL1, 0, 8'h00, 8'h00},
    '{`CRPC_IDX_STOP_RECOVERY_CTRL2, 0, 8'h00, 8'h00}, '{`CRPC_IDX_STOP_RECOVERY_CTRL3, 0, 8'h00, 8'h00},
    '{`CRPC_IDX_WDM, 0, 8'h00, 8'h00}, '{12'h123, 0, 8'h00, 8'h00},
    '{`CRPC_IDX_VDC, 1, 8'hff, 8'hf9}, '{`CRPC_IDX_STOP_RECOVERY_CTRL1, 1, 8'ha5, 8'ha5},
    '{`CRPC_IDX_STOP_RECOVERY_CTRL3, 1, 8'h3c, 8'h3c}, '{`CRPC_IDX_STOP_RECOVERY_CTRL4, 1, 8'h1f, 8'h1f},
    '{`CRPC_IDX_WDM, 1, 8'h0d, 8'h00}, '{12'h123, 1, 8'h5a, 8'h00}};

  always #10 clk = ~clk;

  crpc_top #(.POR_CYC(POR), .WD_CYC(WD)) DUT (
    .SYS_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r), .OSCILLATOR_INPUT_PIN(osc),
    .BROWNOUT_COMPARATOR_LOW(brown), .DEEP_BROWNOUT_COMPARATOR_LOW(deep),
    .WAKE_PIN(wake), .OPTION_DIV2(div2), .STOP_REQ(stop_req),
    .HALT_REQ(halt_req), .IRQ_PENDING(irq), .WATCHDOG_REFRESH(wd_ref),
    .SYSTEM_CLK_EN(sys_en), .CPU_CLK_EN(cpu_en),
    .INTERRUPT_SIDE_CLOCK_EN(int_en), .OSC_ENABLE(osc_en),
    .BROWNOUT_COMP_EN(bo_en), .INTERNAL_RESET_B(irst_b),
    .RESTART_PULSE(rpulse), .RESTART_VECTOR(rvec), .HALT_ACTIVE(halt_a),
    .STOP_ACTIVE(stop_a));

  crpc_osc_model #(.HALF_NS(HALF)) osc_m (.osc_enable(osc_en), .hold(hold),
    .osc_pin(osc));

  // ****
  // Helpers
  // ****
  task fail(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) fail(m);
  endtask

  task rng(input int got, input int lo_b, input int hi_b, input string m);
    checked++;
    if (got < lo_b || got > hi_b) fail(m);
  endtask

  // Held until waitrequest is sampled low, then released
  task bus(input bit w, input logic [11:0] idx, input logic [7:0] v);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_r !== 1'b0) begin
      @(posedge clk);
    end
    d = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task wait_rst(input logic lvl, input int lim);
    n = 0;
    while (irst_b !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Cycles to restart pulse and cycles spent in internal reset
  task wait_restart();
    n = 0;
    lo = 0;
    while (rpulse !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
      lo += (irst_b === 1'b0);
    end
    rng(n, 0, 399, "no restart");
  endtask

  task cnt();
    s = 0;
    c = 0;
    t = 0;
    repeat (WIN) begin
      @(posedge clk);
      s += (sys_en === 1'b1);
      c += (cpu_en === 1'b1);
      t += (int_en === 1'b1);
    end
  endtask

  task end_of_test();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    fail("timeout");
    end_of_test();
  end

  // ****
  // Sequence
  // ****
  initial begin
    repeat (12) @(posedge clk);
    chk(irst_b, 1'b0, "reset held");
    chk(rvec, 12'h00c, "vector");
    rst_b <= 1'b1;
    wait_rst(1'b1, 500);
    rng(n, POR, 499, "por length");
    for (int i = 0; i < 14; i++) begin
      if (rows[i].wr) bus(1, rows[i].idx, rows[i].wd);
      bus(0, rows[i].idx, 8'h00);
      chk(d, rows[i].exp, "register");
    end
    cnt();
    rng(s, E1 - 2, E1 + 2, "div1 sys");
    rng(c, E1 - 2, E1 + 2, "div1 cpu");
    bus(1, `CRPC_IDX_SMR, 8'h21);
    cnt();
    rng(s, E1 / 16 - 1, E1 / 16 + 1, "div16");
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    @(posedge clk);
    chk(halt_a, 1'b1, "halt");
    cnt();
    chk(osc_en, 1'b1, "halt osc");
    rng(c, 0, 0, "halt cpu");
    rng(t, E1 / 16 - 1, E1 / 16 + 1, "halt int");
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    repeat (2) @(posedge clk);
    chk(halt_a, 1'b0, "halt exit");
    bus(1, `CRPC_IDX_SMR, 8'h01);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    @(posedge clk);
    chk(stop_a, 1'b1, "stop");
    cnt();
    chk(osc_en, 1'b0, "stop osc");
    rng(s, 0, 0, "stop sys");
    wake <= 1'b1;
    wait_restart();
    rng(lo, 0, 0, "no delay");
    wake <= 1'b0;
    bus(0, `CRPC_IDX_SMR, 8'h00);
    chk(d, 8'h80, "smr after wake");
    bus(0, `CRPC_IDX_STOP_RECOVERY_CTRL1, 8'h00);
    chk(d, 8'ha5, "kept");
    cnt();
    rng(s, E1 - 2, E1 + 2, "prescaler off");
    bus(1, `CRPC_IDX_SMR, 8'h20);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (3) @(posedge clk);
    wake <= 1'b1;
    wait_restart();
    rng(lo, POR, 399, "delayed wake");
    wake <= 1'b0;
    brown <= 1'b1;
    repeat (5) @(posedge clk);
    chk(irst_b, 1'b0, "brown reset");
    chk(osc_en, 1'b0, "brown osc");
    deep <= 1'b1;
    repeat (5) @(posedge clk);
    chk(bo_en, 1'b0, "deep");
    chk(irst_b, 1'b0, "deep reset");
    hold <= 1'b1;
    deep <= 1'b0;
    brown <= 1'b0;
    repeat (200) @(posedge clk);
    chk(irst_b, 1'b0, "no osc edges");
    hold <= 1'b0;
    wait_rst(1'b1, 300);
    rng(n, 0, 299, "brown recovery");
    bus(0, `CRPC_IDX_STOP_RECOVERY_CTRL1, 8'h00);
    chk(d, 8'h00, "brown defaults");
    div2 <= 1'b1;
    repeat (3) begin
      wd_ref <= 1'b1;
      @(posedge clk);
      wd_ref <= 1'b0;
      repeat (150) @(posedge clk);
      chk(irst_b, 1'b1, "refreshed");
    end
    wait_rst(1'b0, 300);
    rng(n, 40, 70, "watchdog");
    wait_rst(1'b1, 400);
    cnt();
    rng(s, E1 / 2 - 2, E1 / 2 + 2, "div2");
    bus(0, `CRPC_IDX_SMR, 8'h00);
    chk(d, 8'h20, "wd defaults");
    end_of_test();
  end
endmodule
